/* File: src/mmag_pkg.sv */
package mmag_pkg;
  // ****************************************
  // register map, word aligned byte offsets
  // ****************************************
  localparam logic [11:0] MMAG_REG_MODE = 12'h000;
  localparam logic [11:0] MMAG_REG_STAT = 12'h004;
  localparam logic [11:0] MMAG_REG_ACTL = 12'h008;
  localparam logic [11:0] MMAG_REG_RGHT = 12'h00C;
  localparam logic [11:0] MMAG_REG_SEC = 12'h010;
  localparam logic [11:0] MMAG_REG_CAUS = 12'h014;
  // ****************************************
  // privilege states and request codes
  // ****************************************
  typedef enum logic [3:0] {
    MMAG_BOOT = 4'b0001,
    MMAG_TEST = 4'b0010,
    MMAG_VEND = 4'b0100,
    MMAG_APP = 4'b1000
  } mmag_mode_e;
  localparam logic [1:0] MMAG_RQ_TEST = 2'h1;
  localparam logic [1:0] MMAG_RQ_VEND = 2'h2;
  localparam logic [1:0] MMAG_RQ_APP = 2'h3;
  // ****************************************
  // memory layout
  // ****************************************
  localparam logic [1:0] MMAG_RG_NVM = 2'h0;
  localparam logic [1:0] MMAG_RG_PER = 2'h3;
  // index 2 rom, 1 ram, 0 nvm
  localparam logic [2:0][14:0] MMAG_MSIZE = {15'h4000, 15'h1000, 15'h4000};
  localparam logic [14:0] MMAG_ROWS = 15'h3E00;
  localparam logic [8:0] MMAG_RO_END = 9'h020;
  localparam logic [8:0] MMAG_WP_END = 9'h030;
  localparam logic [8:0] MMAG_WO_END = 9'h050;
  localparam logic [8:0] MMAG_PDC_END = 9'h060;
  localparam int unsigned MMAG_SPL_SH = 6;
  localparam int unsigned MMAG_SPL_W = 8;
  localparam logic [3:0] MMAG_NGRP = 4'hE;
  // ****************************************
  // fuse word fields
  // ****************************************
  localparam int unsigned MMAG_F_DELIV = 24;
  localparam int unsigned MMAG_F_LOCK = 25;
  localparam int unsigned MMAG_F_WIPE = 26;
  localparam int unsigned MMAG_F_EMU = 27;
  localparam int unsigned MMAG_F_CDIS = 28;
  localparam int unsigned MMAG_F_WPL = 29;
  localparam logic [7:0] MMAG_CRC_POLY = 8'h07;
  localparam logic [7:0] MMAG_CRC_INIT = 8'h00;
  // ****************************************
  // control bits, reset values, causes
  // ****************************************
  localparam int unsigned MMAG_AC_WPL = 0;
  localparam int unsigned MMAG_AC_DIS = 1;
  localparam int unsigned MMAG_AC_WIPE = 2;
  localparam logic [7:0] MMAG_SEC_RST = 8'hFF;
  localparam logic [3:0] MMAG_C_NONE = 4'h0;
  localparam logic [3:0] MMAG_C_OOB = 4'h1;
  localparam logic [3:0] MMAG_C_PART = 4'h2;
  localparam logic [3:0] MMAG_C_PROT = 4'h3;
  localparam logic [3:0] MMAG_C_DENY = 4'h4;
  localparam logic [3:0] MMAG_C_UNIM = 4'h5;
  localparam logic [3:0] MMAG_C_MODE = 4'h6;
  localparam logic [3:0] MMAG_C_CRC = 4'h7;
  localparam logic [3:0] MMAG_C_REG = 4'h8;
endpackage

/* File: src/mmag_guard.sv */
`timescale 1ns/1ps
// Function
// - start-up may go up, never come back
// - factory check barred once delivered
// - start-up only after reset
// - top 512 bytes hidden from application beyond the three user areas
// - read-only area refuses application writes
// - protectable area locks on request
// - set-once area only sets bits
// - configuration values hidden from application
// - disabled card never starts application when the lock fuse option is set
// - wipe option erases application data
// - fuse transfer checked by crc
// - every cpu address translated
// - vendor states see vendor partitions only
// - application sees application partitions only
// - factory check reaches all partitions
// - partition bounds fixed after load
// - out-of-bounds raises exception except check
// - group rights gate vendor register access
// - application cannot toggle security mechanisms
// - denied or missing peripheral register raises exception
module mmag_guard (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fuse_valid,
  input wire logic [31:0] fuse_cfg,
  input wire logic [7:0] fuse_crc,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_vaddr,
  input wire logic [7:0] cpu_wdata,
  input wire logic erase_done,
  output logic mem_req,
  output logic mem_we,
  output logic mem_bitset,
  output logic [1:0] mem_tgt,
  output logic [14:0] mem_paddr,
  output logic [7:0] mem_wdata,
  output logic exc,
  output logic [3:0] exc_cause,
  output logic [3:0] mode,
  output logic card_disabled,
  output logic erase_req,
  output logic wp_locked,
  output logic [7:0] sec_ctrl
);
  // ****************************************
  // state
  // ****************************************
  mmag_pkg::mmag_mode_e mode_r;
  mmag_pkg::mmag_mode_e req_mode;
  logic [31:0] cfg_r;
  logic cfg_ok_r;
  logic crc_err_r;
  logic wp_lock_r;
  logic card_dis_r;
  logic erase_req_r;
  logic [13:0] rights_r;
  logic [7:0] sec_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [3:0] apb_cause_r;
  logic mem_req_r;
  logic mem_we_r;
  logic mem_bitset_r;
  logic [1:0] mem_tgt_r;
  logic [14:0] mem_paddr_r;
  logic [7:0] mem_wdata_r;
  logic exc_r;
  logic [3:0] exc_cause_r;
  logic exc_nxt;
  logic [3:0] cause_nxt;

  // serial crc over the fuse word, msb first
  function automatic logic [7:0] mmag_crc8(input logic [31:0] d);
    logic [7:0] c;
    c = mmag_pkg::MMAG_CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? mmag_pkg::MMAG_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // mode decode
  wire is_boot = mode_r == mmag_pkg::MMAG_BOOT;
  wire is_test = mode_r == mmag_pkg::MMAG_TEST;
  wire is_vend = mode_r == mmag_pkg::MMAG_VEND;
  wire is_app = mode_r == mmag_pkg::MMAG_APP;
  wire deliv = cfg_r[mmag_pkg::MMAG_F_DELIV];
  wire lock_opt = cfg_r[mmag_pkg::MMAG_F_LOCK];
  wire wipe_opt = cfg_r[mmag_pkg::MMAG_F_WIPE];
  wire emu_opt = cfg_r[mmag_pkg::MMAG_F_EMU];

  // ****************************************
  // fuse transfer
  // ****************************************
  // a bad crc leaves config unloaded, so start-up cannot be left
  wire crc_ok = mmag_crc8(fuse_cfg) == fuse_crc;
  wire fuse_take = fuse_valid & is_boot & ~cfg_ok_r;
  wire fuse_ld = fuse_take & crc_ok;
  wire fuse_exc = fuse_take & ~crc_ok;

  // config has no bus write path, only the one load in start-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 32'h0000_0000;
      cfg_ok_r <= 1'b0;
      crc_err_r <= 1'b0;
    end else if (fuse_take) begin
      if (crc_ok) begin
        cfg_r <= fuse_cfg;
      end
      cfg_ok_r <= crc_ok;
      crc_err_r <= ~crc_ok;
    end
  end

  // ****************************************
  // partition bounds per memory type
  // ****************************************
  wire [14:0] split_w [0:2];
  wire [14:0] atop_w [0:2];
  for (genvar t = 0; t < 3; t++) begin : g_part
    wire [14:0] raw = 15'(cfg_r[t*mmag_pkg::MMAG_SPL_W +: mmag_pkg::MMAG_SPL_W])
      << mmag_pkg::MMAG_SPL_SH;
    // nvm application space stops below the protected rows
    wire [14:0] top = (t == 0) ? mmag_pkg::MMAG_ROWS : mmag_pkg::MMAG_MSIZE[t];
    assign split_w[t] = (raw > top) ? top : raw;
    // emulation runs application code from nvm, so no rom share
    assign atop_w[t] = (t == 2 && emu_opt) ? split_w[t] : top;
  end

  // ****************************************
  // cpu access decode and translation
  // ****************************************
  wire [1:0] region = cpu_vaddr[15:14];
  wire is_mem = region != mmag_pkg::MMAG_RG_PER;
  wire [1:0] mi = is_mem ? region : mmag_pkg::MMAG_RG_NVM;
  wire [14:0] off = {1'b0, cpu_vaddr[13:0]};
  wire [14:0] msize = mmag_pkg::MMAG_MSIZE[mi];
  wire [15:0] app_sum = {1'b0, split_w[mi]} + {1'b0, off};
  wire [14:0] app_span = atop_w[mi] - split_w[mi];
  // application offsets start at the split, vendor at zero
  wire [14:0] mem_pa = is_app ? app_sum[14:0] : off;
  wire phys_ok = is_app ? (app_sum < {1'b0, msize}) : (off < msize);
  wire part_ok = is_test | (is_app ? (off < app_span) : (off < split_w[mi]));

  // protected rows sit at fixed reserved addresses
  wire in_rows = (region == mmag_pkg::MMAG_RG_NVM) & (off >= mmag_pkg::MMAG_ROWS);
  wire [8:0] row_off = off[8:0];
  wire in_ro = row_off < mmag_pkg::MMAG_RO_END;
  wire in_wp = ~in_ro & (row_off < mmag_pkg::MMAG_WP_END);
  wire in_wo = (row_off >= mmag_pkg::MMAG_WP_END) & (row_off < mmag_pkg::MMAG_WO_END);
  wire in_pdc = (row_off >= mmag_pkg::MMAG_WO_END) & (row_off < mmag_pkg::MMAG_PDC_END);
  // application reads the three user areas only
  wire row_rd_ok = ~is_app | in_ro | in_wp | in_wo;
  wire row_wr_ok = ~is_app | (in_wp & ~wp_lock_r) | in_wo;
  wire row_ok = cpu_we ? row_wr_ok : row_rd_ok;

  // peripheral register groups
  wire [3:0] grp = cpu_vaddr[11:8];
  wire per_impl = (cpu_vaddr[13:12] == 2'b00) & (grp < mmag_pkg::MMAG_NGRP);
  wire [15:0] rights_x = {2'b00, rights_r};
  wire per_right = ~is_vend | rights_x[grp];

  // cause selection, test mode oob is dropped silently
  wire [3:0] per_cause = ~per_impl ? mmag_pkg::MMAG_C_UNIM :
    (~per_right ? mmag_pkg::MMAG_C_DENY : mmag_pkg::MMAG_C_NONE);
  wire [3:0] row_cause = row_ok ? mmag_pkg::MMAG_C_NONE : mmag_pkg::MMAG_C_PROT;
  wire [3:0] mem_cause = (~phys_ok & ~is_test) ? mmag_pkg::MMAG_C_OOB :
    (~part_ok ? mmag_pkg::MMAG_C_PART : mmag_pkg::MMAG_C_NONE);
  wire [3:0] acc_cause = ~is_mem ? per_cause : (in_rows ? row_cause : mem_cause);
  wire acc_grant = (acc_cause == mmag_pkg::MMAG_C_NONE) & (~is_mem | in_rows | phys_ok);
  wire go = cpu_req & acc_grant;
  wire [14:0] acc_pa = ~is_mem ? {3'b000, cpu_vaddr[11:0]} : (in_rows ? off : mem_pa);
  wire cpu_exc = cpu_req & (acc_cause != mmag_pkg::MMAG_C_NONE);

  // refused requests never reach memory, so contents stay intact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_bitset_r <= 1'b0;
      mem_tgt_r <= 2'h0;
      mem_paddr_r <= 15'h0000;
      mem_wdata_r <= 8'h00;
    end else begin
      mem_req_r <= go;
      mem_we_r <= go & cpu_we;
      mem_bitset_r <= go & cpu_we & in_rows & in_wo;
      mem_tgt_r <= region;
      mem_paddr_r <= acc_pa;
      mem_wdata_r <= cpu_wdata;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  wire apb_setup = psel & ~penable;
  wire hit_mode = paddr == mmag_pkg::MMAG_REG_MODE;
  wire hit_stat = paddr == mmag_pkg::MMAG_REG_STAT;
  wire hit_actl = paddr == mmag_pkg::MMAG_REG_ACTL;
  wire hit_rght = paddr == mmag_pkg::MMAG_REG_RGHT;
  wire hit_sec = paddr == mmag_pkg::MMAG_REG_SEC;
  wire hit_caus = paddr == mmag_pkg::MMAG_REG_CAUS;
  wire hit_any = hit_mode | hit_stat | hit_actl | hit_rght | hit_sec | hit_caus;

  // legal moves; nothing ever returns to start-up
  wire [1:0] rq = pwdata[1:0];
  wire from_boot = is_boot & cfg_ok_r;
  wire app_locked = lock_opt & card_dis_r;
  wire mode_legal = (rq == mmag_pkg::MMAG_RQ_TEST) ? (from_boot & ~deliv) :
    (rq == mmag_pkg::MMAG_RQ_VEND) ? (from_boot | is_test | is_app) :
    (rq == mmag_pkg::MMAG_RQ_APP) ? ((from_boot | is_test | is_vend) & ~app_locked) :
    1'b0;
  assign req_mode = (rq == mmag_pkg::MMAG_RQ_TEST) ? mmag_pkg::MMAG_TEST :
    (rq == mmag_pkg::MMAG_RQ_VEND) ? mmag_pkg::MMAG_VEND : mmag_pkg::MMAG_APP;

  // write refusals; security control is closed to application code
  wire wr_refuse = (hit_mode & ~mode_legal) | ((hit_actl | hit_rght) & ~is_app) |
    (hit_sec & is_app) | hit_stat | hit_caus;
  wire apb_err = ~hit_any | (pwrite & wr_refuse);
  wire [31:0] stat_w = {23'h0, emu_opt, wipe_opt, lock_opt, erase_req_r, card_dis_r,
    wp_lock_r, deliv, crc_err_r, cfg_ok_r};
  wire [31:0] rd_mux = hit_mode ? {28'h0, mode_r} : hit_stat ? stat_w :
    hit_rght ? {18'h0, rights_r} : hit_sec ? {24'h0, sec_r} :
    hit_caus ? {28'h0, exc_cause_r} : 32'h0000_0000;
  wire apb_done = psel & penable & pready_r;
  wire wr_go = apb_done & pwrite & ~pslverr_r;
  wire wr_refused = apb_done & pwrite & pslverr_r & hit_any;
  wire actl_go = wr_go & hit_actl;
  wire wipe_set = actl_go & pwdata[mmag_pkg::MMAG_AC_WIPE] & wipe_opt;

  // answer is prepared in setup so every apb output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      apb_cause_r <= mmag_pkg::MMAG_C_NONE;
    end else begin
      pready_r <= apb_setup;
      if (apb_setup) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_r <= apb_err;
        apb_cause_r <= hit_mode ? mmag_pkg::MMAG_C_MODE : mmag_pkg::MMAG_C_REG;
      end
    end
  end

  // privilege state, start-up only out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= mmag_pkg::MMAG_BOOT;
    end else if (wr_go & hit_mode) begin
      mode_r <= req_mode;
    end
  end

  // sticky lock and disable; only reset clears them, fuses restore them; erase_done ends the wipe request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_lock_r <= 1'b0;
      card_dis_r <= 1'b0;
      erase_req_r <= 1'b0;
    end else begin
      wp_lock_r <= wp_lock_r | (fuse_ld & fuse_cfg[mmag_pkg::MMAG_F_WPL]) |
        (actl_go & pwdata[mmag_pkg::MMAG_AC_WPL]);
      card_dis_r <= card_dis_r | (fuse_ld & fuse_cfg[mmag_pkg::MMAG_F_CDIS]) |
        (actl_go & pwdata[mmag_pkg::MMAG_AC_DIS] & lock_opt);
      erase_req_r <= wipe_set | (erase_req_r & ~erase_done);
    end
  end

  // group rights and security controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rights_r <= 14'h0000;
      sec_r <= mmag_pkg::MMAG_SEC_RST;
    end else begin
      if (wr_go & hit_rght) begin
        rights_r <= pwdata[13:0];
      end
      if (wr_go & hit_sec) begin
        sec_r <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // exception reporting
  // ****************************************
  // cpu fault outranks bus refusal, which outranks crc failure
  assign exc_nxt = cpu_exc | wr_refused | fuse_exc;
  assign cause_nxt = cpu_exc ? acc_cause : wr_refused ? apb_cause_r :
    fuse_exc ? mmag_pkg::MMAG_C_CRC : exc_cause_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_r <= 1'b0;
      exc_cause_r <= mmag_pkg::MMAG_C_NONE;
    end else begin
      exc_r <= exc_nxt;
      exc_cause_r <= cause_nxt;
    end
  end

  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_bitset = mem_bitset_r;
  assign mem_tgt = mem_tgt_r;
  assign mem_paddr = mem_paddr_r;
  assign mem_wdata = mem_wdata_r;
  assign exc = exc_r;
  assign exc_cause = exc_cause_r;
  assign mode = mode_r;
  assign card_disabled = card_dis_r;
  assign erase_req = erase_req_r;
  assign wp_locked = wp_lock_r;
  assign sec_ctrl = sec_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  boot_gone_a: assert property (!is_boot |=> !is_boot)
    else $error("start-up state re-entered");
  test_bar_a: assert property (deliv && !is_test |=> !is_test)
    else $error("factory check entered after delivery");
  boot_hold_a: assert property (is_boot && !cfg_ok_r |=> is_boot)
    else $error("start-up left before config load");
  rows_hide_a: assert property (cpu_req && is_app && in_rows && !in_ro && !in_wp && !in_wo
    |=> !mem_req_r && exc_r)
    else $error("application reached hidden rows");
  ro_write_a: assert property (cpu_req && cpu_we && is_app && in_rows && in_ro
    |=> !mem_we_r && exc_cause_r == mmag_pkg::MMAG_C_PROT)
    else $error("read-only area written");
  wp_write_a: assert property (cpu_req && cpu_we && is_app && in_rows && in_wp && wp_lock_r
    |=> !mem_we_r && exc_r)
    else $error("locked area written");
  wo_set_a: assert property (cpu_req && cpu_we && in_rows && in_wo |=> mem_bitset_r)
    else $error("set-once write not bit-set");
  pdc_a: assert property (cpu_req && in_rows && in_pdc |=> mem_req_r == !$past(is_app))
    else $error("configuration values access wrong");
  lockout_a: assert property (app_locked && !is_app |=> !is_app)
    else $error("application started on disabled card");
  wipe_a: assert property (wipe_set ##1 !erase_done [*2] |-> erase_req_r)
    else $error("wipe request lost");
  crc_a: assert property (fuse_take && !crc_ok && !cpu_req
    |=> !cfg_ok_r && exc_cause_r == mmag_pkg::MMAG_C_CRC)
    else $error("bad crc accepted");
  xlat_a: assert property (cpu_req && is_app && region == mmag_pkg::MMAG_RG_NVM && off == 15'h0
    |=> mem_paddr_r == $past(split_w[0]))
    else $error("application base not translated");
  vend_part_a: assert property (cpu_req && !is_app && !is_test && is_mem && !in_rows
    && off >= split_w[mi] |=> !mem_req_r && exc_r)
    else $error("vendor state left its partition");
  test_all_a: assert property (cpu_req && is_test && is_mem && off < msize
    |=> mem_req_r && mem_paddr_r == $past(off))
    else $error("factory check access blocked");
  cfg_fix_a: assert property (cfg_ok_r |=> $stable(cfg_r))
    else $error("partition config changed");
  oob_a: assert property (cpu_req && is_mem && !in_rows && !phys_ok
    |=> !mem_req_r && (exc_r || $past(is_test)))
    else $error("out-of-bounds access not handled");
  grp_a: assert property (cpu_req && !is_mem && is_vend && per_impl && !per_right
    |=> exc_cause_r == mmag_pkg::MMAG_C_DENY)
    else $error("denied group reached");
  sec_fix_a: assert property (is_app ##1 is_app |-> $stable(sec_r))
    else $error("application changed security control");
  unim_a: assert property (cpu_req && !is_mem && !per_impl
    |=> exc_r && !mem_req_r)
    else $error("missing register not reported");

  boot_app_c: cover property (is_boot ##1 is_app);
  vend_ret_c: cover property (is_app ##1 is_vend ##[1:20] is_app);
  wo_set_c: cover property (mem_bitset_r);
  deny_c: cover property (exc_r && exc_cause_r == mmag_pkg::MMAG_C_DENY);
endmodule // mmag_guard

/* File: testbench/mmag_cpu_model.sv */
`timescale 1ns/1ps
// ****************************************
// cpu core stand-in, one byte access a call
// ****************************************
module mmag_cpu_model (
  input wire logic pclk,
  output logic cpu_req,
  output logic cpu_we,
  output logic [15:0] cpu_vaddr,
  output logic [7:0] cpu_wdata,
  input wire logic mem_req,
  input wire logic mem_bitset,
  input wire logic [14:0] mem_paddr,
  input wire logic exc,
  input wire logic [3:0] exc_cause
);
  // quiet core at time zero
  initial begin
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_vaddr = 16'h0000;
    cpu_wdata = 8'h00;
  end
  // idle lines flip so a stale address never passes for a live one
  task automatic access(input logic we, input logic [15:0] va, input logic [7:0] wd,
      output logic g, output logic bs, output logic [14:0] pa, output logic ex,
      output logic [3:0] c);
    @(posedge pclk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_vaddr <= va;
    cpu_wdata <= wd;
    @(posedge pclk);
    cpu_req <= 1'b0;
    cpu_we <= ~we;
    cpu_vaddr <= ~va;
    cpu_wdata <= ~wd;
    @(posedge pclk);
    g = mem_req;
    bs = mem_bitset;
    pa = mem_paddr;
    ex = exc;
    c = exc_cause;
  endtask
endmodule // mmag_cpu_model

/* File: testbench/mmag_guard_bench.sv */
`timescale 1ns/1ps
module mmag_guard_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fuse_valid = 1'b0;
  logic [31:0] fuse_cfg = 32'h0;
  logic [7:0] fuse_crc = 8'h00;
  logic erase_done = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_req, cpu_we, mem_req, mem_we, mem_bitset, exc;
  logic card_disabled, erase_req, wp_locked;
  logic [15:0] cpu_vaddr;
  logic [7:0] cpu_wdata, mem_wdata, sec_ctrl;
  logic [1:0] mem_tgt;
  logic [14:0] mem_paddr;
  logic [3:0] exc_cause, mode;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [31:0] CFG_A = 32'h0020_0810;
  localparam logic [31:0] CFG_B = 32'h0F20_0810;
  localparam logic [3:0] NOREQ = 4'hF;
  localparam logic [3:0] OK = mmag_pkg::MMAG_C_NONE;

  always #10 pclk = ~pclk;

  mmag_guard mmag_guard_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse_valid(fuse_valid), .fuse_cfg(fuse_cfg),
    .fuse_crc(fuse_crc), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_vaddr(cpu_vaddr),
    .cpu_wdata(cpu_wdata), .erase_done(erase_done), .mem_req(mem_req), .mem_we(mem_we),
    .mem_bitset(mem_bitset), .mem_tgt(mem_tgt), .mem_paddr(mem_paddr),
    .mem_wdata(mem_wdata), .exc(exc), .exc_cause(exc_cause), .mode(mode),
    .card_disabled(card_disabled), .erase_req(erase_req), .wp_locked(wp_locked),
    .sec_ctrl(sec_ctrl));
  mmag_cpu_model mmag_cpu_model_inst (.pclk(pclk), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_vaddr(cpu_vaddr), .cpu_wdata(cpu_wdata), .mem_req(mem_req),
    .mem_bitset(mem_bitset), .mem_paddr(mem_paddr), .exc(exc), .exc_cause(exc_cause));

  // ****************************************
  // shared tasks
  // ****************************************
  // hang guard: a few thousand cycles is far beyond the whole run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [31:0] v);
    logic [7:0] c;
    c = mmag_pkg::MMAG_CRC_INIT;
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic rst();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit of its own; only the hang guard ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk(err, ee);
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic ee);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(err, ee);
    chk(rd & m, e);
  endtask
  // mode request; a refusal raises its exception at the commit edge, its cause is checked two edges later
  task automatic mw(input logic [31:0] d, input logic ee, input logic [3:0] me);
    wr(mmag_pkg::MMAG_REG_MODE, d, ee);
    @(posedge pclk);
    chk(mode, me);
    @(posedge pclk);
    if (ee) chk(exc_cause, mmag_pkg::MMAG_C_MODE);
  endtask
  task automatic waitc(input logic [3:0] c);
    repeat (2) @(posedge pclk);
    chk(exc_cause, c);
  endtask
  task automatic fuse(input logic [31:0] cfg, input logic good);
    @(posedge pclk);
    fuse_valid <= 1'b1;
    fuse_cfg <= cfg;
    fuse_crc <= good ? crc8(cfg) : ~crc8(cfg);
    @(posedge pclk);
    fuse_valid <= 1'b0;
    fuse_cfg <= ~cfg;
  endtask
  // NOREQ: neither grant nor exception; OK: grant at pa_e
  task automatic cpu(input logic we, input logic [15:0] va, input logic [14:0] pa_e,
      input logic [3:0] ce);
    logic g, bs, ex;
    logic [14:0] pa;
    logic [3:0] c;
    mmag_cpu_model_inst.access(we, va, 8'h5A, g, bs, pa, ex, c);
    chk(g, ce == OK);
    chk(ex, ce != OK && ce != NOREQ);
    // target and data follow every request; the write strobe only a granted one
    chk({mem_we, mem_tgt, mem_wdata}, {we & g, va[15:14], 8'h5A});
    if (ex === 1'b1) chk(c, ce);
    if (g === 1'b1 && va[15:14] != 2'h3) chk(pa, pa_e);
    if (g === 1'b1) chk(bs, we && va >= 16'h3E30 && va < 16'h3E50);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_boot();
    rst();
    chk(mode, mmag_pkg::MMAG_BOOT);
    chk(sec_ctrl, mmag_pkg::MMAG_SEC_RST);
    chk({card_disabled, erase_req, wp_locked, exc}, 4'h0);
    fuse(CFG_A, 1'b0);
    waitc(mmag_pkg::MMAG_C_CRC);
    fuse(CFG_A, 1'b1);
    rdm(mmag_pkg::MMAG_REG_STAT, 32'h3, 32'h1, 1'b0);
    rdm(12'h018, 32'h0, 32'h0, 1'b1);
    cpu(1'b0, 16'h0010, 15'h0010, OK);
    cpu(1'b0, 16'h0400, 15'h0, mmag_pkg::MMAG_C_PART);
    $display("boot test done");
  endtask
  task automatic t_modes();
    mw(32'h1, 1'b0, mmag_pkg::MMAG_TEST);
    cpu(1'b0, 16'h0500, 15'h0500, OK);
    cpu(1'b0, 16'h5000, 15'h0, NOREQ);
    mw(32'h0, 1'b1, mmag_pkg::MMAG_TEST);
    mw(32'h2, 1'b0, mmag_pkg::MMAG_VEND);
    cpu(1'b0, 16'h5000, 15'h0, mmag_pkg::MMAG_C_OOB);
    cpu(1'b0, 16'hC100, 15'h0, mmag_pkg::MMAG_C_DENY);
    cpu(1'b0, 16'hCE00, 15'h0, mmag_pkg::MMAG_C_UNIM);
    wr(mmag_pkg::MMAG_REG_RGHT, 32'h2, 1'b1);
    waitc(mmag_pkg::MMAG_C_REG);
    mw(32'h3, 1'b0, mmag_pkg::MMAG_APP);
    cpu(1'b0, 16'h0005, 15'h0405, OK);
    cpu(1'b0, 16'h8000, 15'h0800, OK);
    cpu(1'b0, 16'h3A00, 15'h0, mmag_pkg::MMAG_C_PART);
    cpu(1'b1, 16'h3E00, 15'h0, mmag_pkg::MMAG_C_PROT);
    cpu(1'b0, 16'h3E1F, 15'h3E1F, OK);
    cpu(1'b1, 16'h3E20, 15'h3E20, OK);
    cpu(1'b1, 16'h3E4F, 15'h3E4F, OK);
    cpu(1'b0, 16'h3E50, 15'h0, mmag_pkg::MMAG_C_PROT);
    wr(mmag_pkg::MMAG_REG_SEC, 32'h0, 1'b1);
    chk(sec_ctrl, mmag_pkg::MMAG_SEC_RST);
    rdm(mmag_pkg::MMAG_REG_SEC, 32'hFFFF_FFFF, {24'h0, mmag_pkg::MMAG_SEC_RST}, 1'b0);
    rdm(mmag_pkg::MMAG_REG_CAUS, 32'hFFFF_FFFF, {28'h0, mmag_pkg::MMAG_C_REG}, 1'b0);
    rdm(mmag_pkg::MMAG_REG_MODE, 32'hFFFF_FFFF, {28'h0, mmag_pkg::MMAG_APP}, 1'b0);
    wr(mmag_pkg::MMAG_REG_RGHT, 32'h2, 1'b0);
    rdm(mmag_pkg::MMAG_REG_RGHT, 32'hFFFF_FFFF, 32'h2, 1'b0);
    wr(mmag_pkg::MMAG_REG_ACTL, 32'h1, 1'b0);
    waitc(mmag_pkg::MMAG_C_REG);
    chk(wp_locked, 1'b1);
    cpu(1'b1, 16'h3E2F, 15'h0, mmag_pkg::MMAG_C_PROT);
    mw(32'h2, 1'b0, mmag_pkg::MMAG_VEND);
    cpu(1'b0, 16'hC100, 15'h0, OK);
    mw(32'h3, 1'b0, mmag_pkg::MMAG_APP);
    $display("mode and partition test done");
  endtask
  task automatic t_deliv();
    rst();
    chk(wp_locked, 1'b0);
    fuse(CFG_B, 1'b1);
    rdm(mmag_pkg::MMAG_REG_STAT, 32'h1C5, 32'h1C5, 1'b0);
    mw(32'h1, 1'b1, mmag_pkg::MMAG_BOOT);
    fuse(CFG_A, 1'b0);
    waitc(mmag_pkg::MMAG_C_MODE);
    mw(32'h3, 1'b0, mmag_pkg::MMAG_APP);
    // emulation leaves no application rom share
    cpu(1'b0, 16'h8000, 15'h0, mmag_pkg::MMAG_C_PART);
    wr(mmag_pkg::MMAG_REG_ACTL, 32'h2, 1'b0);
    repeat (2) @(posedge pclk);
    chk(card_disabled, 1'b1);
    wr(mmag_pkg::MMAG_REG_ACTL, 32'h4, 1'b0);
    repeat (2) @(posedge pclk);
    chk(erase_req, 1'b1);
    erase_done <= 1'b1;
    @(posedge pclk);
    erase_done <= 1'b0;
    @(posedge pclk);
    chk(erase_req, 1'b0);
    mw(32'h2, 1'b0, mmag_pkg::MMAG_VEND);
    mw(32'h3, 1'b1, mmag_pkg::MMAG_VEND);
    $display("delivered part test done");
  endtask

  // main sequence, a fresh reset before each run of fuses
  initial begin
    t_boot();
    t_modes();
    t_deliv();
    stop_test();
  end
endmodule // mmag_guard_bench
